// >>> core/pbu_regs.svh
// Purpose: offsets, field positions and timing counts of the periodic
//          burst / upkeep / nvm sequencer
// Assumes: 100 MHz mclk_in; one slow base tick drives all interval timers
// Notes: Operation list below
// Operation
// RULE1: burst spacing is (burst period count + 1) times burst tick
// RULE2: cyclic burst fires every interval at fixed programmed spacing
// RULE3: timed burst carries timed payload byte only when non-zero
// RULE4: triggered burst carries triggered payload byte only when non-zero
// RULE5: idle setup bit 0 enables upkeep; clear means no upkeep wake
// RULE6: upkeep setup bit 7 picks five-minute tick, else one-second tick
// RULE7: upkeep setup bit 6 raises host interrupt and system clock
// RULE8: upkeep setup bit 5 stores bank to nvm after calibrations
// RULE9: upkeep setup bit 4 converts temperature and battery inputs
// RULE10: upkeep setup bit 3 converts both external inputs
// RULE11: bits 2,1,0 enable pll, slow osc and quick-start calibrations
// RULE12: upkeep sleep is (upkeep period count + 1) times upkeep tick
// RULE13: command 0x04 returns to idle and ends an upkeep cycle
// RULE14: command 0x05 stores bank into nvm with checksum
// RULE15: command 0x06 reloads bank from nvm only if checksum valid
// RULE16: failed reload keeps bank and sets error bit in status two
// RULE17: burst setup bit 0 picks 15 s tick, else 50 ms tick
// RULE18: upkeep tasks run in turn, then store, then timer restarts
`ifndef PBU_REGS_SVH
`define PBU_REGS_SVH

`define PBU_CMD_ADDR 8'h00
`define PBU_STAT1_ADDR 8'h01
`define PBU_STAT2_ADDR 8'h02
`define PBU_IDLE_ADDR 8'h10
`define PBU_BCFG_ADDR 8'h16
`define PBU_BPER_ADDR 8'h17
`define PBU_UCFG_ADDR 8'h1b
`define PBU_UPER_ADDR 8'h1c
`define PBU_TPAY_ADDR 8'h2d
`define PBU_XPAY_ADDR 8'h2e

`define PBU_NREG 7
`define PBU_IX_IDLE 3'h0
`define PBU_IX_BCFG 3'h1
`define PBU_IX_BPER 3'h2
`define PBU_IX_UCFG 3'h3
`define PBU_IX_UPER 3'h4
`define PBU_IX_TPAY 3'h5
`define PBU_IX_XPAY 3'h6
`define PBU_IX_NONE 3'h7
`define PBU_BANK_RST 8'h00

`define PBU_CMD_IDLE 8'h04
`define PBU_CMD_STORE 8'h05
`define PBU_CMD_LOAD 8'h06

`define PBU_IDLE_UPK_EN 0
`define PBU_IDLE_BURST_EN 1
`define PBU_BCFG_TICK 0
`define PBU_UCFG_TICK 7
`define PBU_UCFG_WAKE 6
`define PBU_UCFG_STORE 5
`define PBU_UCFG_INT_ADC 4
`define PBU_UCFG_EXT_ADC 3
`define PBU_UCFG_CAL_PLL 2
`define PBU_UCFG_CAL_SLOW 1
`define PBU_UCFG_CAL_QS 0
`define PBU_STAT1_UPK_BUSY 0
`define PBU_STAT1_CSUM_OK 2
`define PBU_STAT2_LOAD_ERR 0

`define PBU_NTASK 5
`define PBU_CLK_PERIOD_NS 10
`define PBU_BASE_TICK_MS 50
`define PBU_BASE_TICK_CYC (`PBU_BASE_TICK_MS * 1000000 / `PBU_CLK_PERIOD_NS)
`define PBU_BURST_FINE_MS 50
`define PBU_BURST_COARSE_MS 15000
`define PBU_UPK_FINE_MS 1000
`define PBU_UPK_COARSE_MS 300000
`define PBU_BURST_FINE_DIV (`PBU_BURST_FINE_MS / `PBU_BASE_TICK_MS)
`define PBU_BURST_COARSE_DIV (`PBU_BURST_COARSE_MS / `PBU_BASE_TICK_MS)
`define PBU_UPK_FINE_DIV (`PBU_UPK_FINE_MS / `PBU_BASE_TICK_MS)
`define PBU_UPK_COARSE_DIV (`PBU_UPK_COARSE_MS / `PBU_BASE_TICK_MS)

`endif

// >>> core/pbu_pkg.sv
// Purpose: types of the periodic burst / upkeep / nvm sequencer
// Assumes: constants come from pbu_regs.svh
// Notes: none
`include "pbu_regs.svh"

package pbu_pkg;
   typedef logic [7:0] pbu_byte_t;
   typedef pbu_byte_t pbu_bank_t [`PBU_NREG];
   typedef enum logic [2:0] {
      UPK_OFF,
      UPK_SLEEP,
      UPK_TASK,
      UPK_STORE,
      UPK_HOLD
   } pbu_upk_state_t;
endpackage

// >>> core/pbu_tick.sv
// Purpose: interval timer counting (period + 1) * div base ticks
// Assumes: base_tick_in is a one-cycle pulse on mclk_in
// Notes: dropping run_in clears the count, so each run starts afresh
`timescale 1ns/1ps
`include "pbu_regs.svh"

module pbu_tick
   import pbu_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rstn_in,
   input wire logic base_tick_in,
   input wire logic run_in,
   input wire logic [12:0] div_in,
   input wire logic [7:0] period_in,
   output logic expire_out
);
   logic [12:0] sub_q;
   logic [7:0] cnt_q;

   always_ff @(posedge mclk_in) begin
      if (!rstn_in || !run_in) begin
         sub_q <= 13'h0000;
         cnt_q <= 8'h00;
         expire_out <= 1'b0;
      end else begin
         expire_out <= 1'b0;
         if (base_tick_in) begin
            if (sub_q >= div_in - 13'h0001) begin
               sub_q <= 13'h0000;
               // period + 1 slow ticks per interval, see RULE1 RULE12
               if (cnt_q >= period_in) begin
                  cnt_q <= 8'h00;
                  expire_out <= 1'b1;
               end else begin
                  cnt_q <= cnt_q + 8'h01;
               end
            end else begin
               sub_q <= sub_q + 13'h0001;
            end
         end
      end
   end

   chk_expire_at_period: assert property ( // see RULE12
      @(posedge mclk_in) disable iff (!rstn_in)
      (run_in && expire_out) |-> $past(cnt_q) == $past(period_in))
      else $error("interval expired before the programmed count");
endmodule

// >>> core/pbu_top.sv
// Purpose: burst timing, upkeep cycle sequencing and nvm store/load
// Assumes: register port and task_done_in are on mclk_in; burst_trig_in
//          is a pin and is synchronised
// Notes: nvm is modelled as an on-chip array reset to an all-zero image
`timescale 1ns/1ps
`include "pbu_regs.svh"

module pbu_top
   import pbu_pkg::*;
#(
   parameter int BASE_TICK_CYC = `PBU_BASE_TICK_CYC
)
(
   input wire logic mclk_in,
   input wire logic rstn_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic burst_trig_in,
   input wire logic task_done_in,
   output logic [7:0] reg_rdata_out,
   output logic burst_tx_out,
   output logic burst_src_out,
   output logic burst_payload_valid_out,
   output logic [7:0] burst_payload_out,
   output logic [4:0] task_req_out,
   output logic host_irq_out,
   output logic sysclk_en_out,
   output logic nvm_store_out
);
   pbu_bank_t bank_q;
   pbu_bank_t nvm_q;
   pbu_byte_t nvm_sum_q;
   logic trig_meta_q, trig_sync_q, trig_old_q;
   logic [22:0] base_cnt_q;
   logic base_tick_q;
   logic csum_ok_q, load_err_q;
   pbu_upk_state_t upk_state_q;
   logic [2:0] task_ix_q;
   logic cmd_wr, idle_ret, store_go, load_go, load_ok, stat2_clr;
   logic burst_exp, upk_exp, trig_edge, upk_en, burst_en;
   logic [12:0] burst_div, upk_div;
   logic [4:0] task_en;
   logic [2:0] wr_ix;
   pbu_byte_t rd_val, ucfg;

   function automatic logic [2:0] addr_ix(input logic [7:0] a);
      unique case (a)
         `PBU_IDLE_ADDR: addr_ix = `PBU_IX_IDLE;
         `PBU_BCFG_ADDR: addr_ix = `PBU_IX_BCFG;
         `PBU_BPER_ADDR: addr_ix = `PBU_IX_BPER;
         `PBU_UCFG_ADDR: addr_ix = `PBU_IX_UCFG;
         `PBU_UPER_ADDR: addr_ix = `PBU_IX_UPER;
         `PBU_TPAY_ADDR: addr_ix = `PBU_IX_TPAY;
         `PBU_XPAY_ADDR: addr_ix = `PBU_IX_XPAY;
         default: addr_ix = `PBU_IX_NONE;
      endcase
   endfunction

   // inverted byte sum, so an all-zero image carries a valid 8'hff
   function automatic pbu_byte_t csum(input pbu_bank_t b);
      pbu_byte_t s;
      s = 8'h00;
      for (int i = 0; i < `PBU_NREG; i++) begin
         s = s + b[i];
      end
      csum = ~s;
   endfunction

   // first enabled upkeep task at or after index from; 5 means none
   function automatic logic [2:0] first_task(input logic [4:0] en,
                                             input logic [2:0] from);
      logic [2:0] f;
      f = 3'(`PBU_NTASK);
      for (int i = `PBU_NTASK - 1; i >= 0; i--) begin
         if (en[i] && 3'(i) >= from) begin
            f = 3'(i);
         end
      end
      first_task = f;
   endfunction

   assign ucfg = bank_q[`PBU_IX_UCFG];
   assign upk_en = bank_q[`PBU_IX_IDLE][`PBU_IDLE_UPK_EN];
   assign burst_en = bank_q[`PBU_IX_IDLE][`PBU_IDLE_BURST_EN];
   // task order: int adc, ext adc, pll, slow osc, quick-start osc
   assign task_en = {ucfg[`PBU_UCFG_CAL_QS], // see RULE11
                     ucfg[`PBU_UCFG_CAL_SLOW],
                     ucfg[`PBU_UCFG_CAL_PLL],
                     ucfg[`PBU_UCFG_EXT_ADC], // see RULE10
                     ucfg[`PBU_UCFG_INT_ADC]}; // see RULE9
   assign cmd_wr = reg_wr_in && reg_addr_in == `PBU_CMD_ADDR;
   assign idle_ret = cmd_wr && reg_wdata_in == `PBU_CMD_IDLE; // see RULE13
   assign load_go = cmd_wr && reg_wdata_in == `PBU_CMD_LOAD;
   assign store_go = (cmd_wr && reg_wdata_in == `PBU_CMD_STORE) // see RULE14
                     || upk_state_q == UPK_STORE; // see RULE8
   assign load_ok = csum(nvm_q) == nvm_sum_q;
   assign stat2_clr = reg_wr_in && reg_addr_in == `PBU_STAT2_ADDR
                      && reg_wdata_in[`PBU_STAT2_LOAD_ERR];
   assign wr_ix = addr_ix(reg_addr_in);
   assign trig_edge = trig_sync_q && !trig_old_q;

   // tick resolutions, see RULE17 RULE6
   assign burst_div = bank_q[`PBU_IX_BCFG][`PBU_BCFG_TICK]
                      ? 13'(`PBU_BURST_COARSE_DIV)
                      : 13'(`PBU_BURST_FINE_DIV);
   assign upk_div = ucfg[`PBU_UCFG_TICK] ? 13'(`PBU_UPK_COARSE_DIV)
                                         : 13'(`PBU_UPK_FINE_DIV);

   // trigger pin passes two flops before the edge detector
   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         trig_meta_q <= 1'b0;
         trig_sync_q <= 1'b0;
         trig_old_q <= 1'b0;
      end else begin
         trig_meta_q <= burst_trig_in;
         trig_sync_q <= trig_meta_q;
         trig_old_q <= trig_sync_q;
      end
   end

   // one shared 50 ms prescaler keeps the interval counters narrow
   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         base_cnt_q <= 23'h000000;
         base_tick_q <= 1'b0;
      end else if (base_cnt_q >= 23'(BASE_TICK_CYC - 1)) begin
         base_cnt_q <= 23'h000000;
         base_tick_q <= 1'b1;
      end else begin
         base_cnt_q <= base_cnt_q + 23'h000001;
         base_tick_q <= 1'b0;
      end
   end

   // burst timer runs free while enabled: fixed cyclic spacing
   pbu_tick u_burst_tick (
      .mclk_in(mclk_in),
      .rstn_in(rstn_in),
      .base_tick_in(base_tick_q),
      .run_in(burst_en), // see RULE2
      .div_in(burst_div),
      .period_in(bank_q[`PBU_IX_BPER]), // see RULE1
      .expire_out(burst_exp)
   );

   // upkeep timer only runs asleep, so it restarts after every cycle
   pbu_tick u_upk_tick (
      .mclk_in(mclk_in),
      .rstn_in(rstn_in),
      .base_tick_in(base_tick_q),
      .run_in(upk_state_q == UPK_SLEEP), // see RULE18
      .div_in(upk_div),
      .period_in(bank_q[`PBU_IX_UPER]), // see RULE12
      .expire_out(upk_exp)
   );

   // working bank: reload wins over a host write in the same cycle
   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         for (int i = 0; i < `PBU_NREG; i++) begin
            bank_q[i] <= `PBU_BANK_RST;
         end
      end else if (load_go && load_ok) begin
         bank_q <= nvm_q; // see RULE15
      end else if (reg_wr_in && wr_ix != `PBU_IX_NONE) begin
         bank_q[wr_ix] <= reg_wdata_in;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         for (int i = 0; i < `PBU_NREG; i++) begin
            nvm_q[i] <= `PBU_BANK_RST;
         end
         nvm_sum_q <= ~`PBU_BANK_RST;
         nvm_store_out <= 1'b0;
      end else begin
         nvm_store_out <= store_go;
         if (store_go) begin
            nvm_q <= bank_q; // see RULE14
            nvm_sum_q <= csum(bank_q);
         end
      end
   end

   // load error is sticky; a new failure wins over a host clear
   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         csum_ok_q <= 1'b0;
         load_err_q <= 1'b0;
      end else begin
         if (load_go) begin
            csum_ok_q <= load_ok;
         end
         if (load_go && !load_ok) begin
            load_err_q <= 1'b1; // see RULE16
         end else if (stat2_clr) begin
            load_err_q <= 1'b0;
         end
      end
   end

   // a trigger landing on a timer expiry is dropped: timed burst wins
   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         burst_tx_out <= 1'b0;
         burst_src_out <= 1'b0;
         burst_payload_valid_out <= 1'b0;
         burst_payload_out <= 8'h00;
      end else begin
         burst_tx_out <= burst_en && (burst_exp || trig_edge);
         if (burst_en && burst_exp) begin
            burst_src_out <= 1'b0;
            burst_payload_out <= bank_q[`PBU_IX_TPAY];
            burst_payload_valid_out <=
               bank_q[`PBU_IX_TPAY] != 8'h00; // see RULE3
         end else if (burst_en && trig_edge) begin
            burst_src_out <= 1'b1;
            burst_payload_out <= bank_q[`PBU_IX_XPAY];
            burst_payload_valid_out <=
               bank_q[`PBU_IX_XPAY] != 8'h00; // see RULE4
         end
      end
   end

   // upkeep cycle: wake, tasks in turn, optional store, optional hold
   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         upk_state_q <= UPK_OFF;
         task_ix_q <= 3'h0;
         task_req_out <= 5'h00;
         host_irq_out <= 1'b0;
         sysclk_en_out <= 1'b0;
      end else begin
         unique case (upk_state_q)
            UPK_OFF: begin
               if (upk_en) begin
                  upk_state_q <= UPK_SLEEP; // see RULE5
               end
            end
            UPK_SLEEP: begin
               if (!upk_en) begin
                  upk_state_q <= UPK_OFF; // see RULE5
               end else if (upk_exp) begin
                  host_irq_out <= ucfg[`PBU_UCFG_WAKE]; // see RULE7
                  sysclk_en_out <= ucfg[`PBU_UCFG_WAKE];
                  task_ix_q <= first_task(task_en, 3'h0);
                  if (first_task(task_en, 3'h0) < 3'(`PBU_NTASK)) begin
                     upk_state_q <= UPK_TASK; // see RULE18
                     task_req_out <= 5'(5'h01 << first_task(task_en, 3'h0));
                  end else if (ucfg[`PBU_UCFG_STORE]) begin
                     upk_state_q <= UPK_STORE;
                  end else if (ucfg[`PBU_UCFG_WAKE]) begin
                     upk_state_q <= UPK_HOLD;
                  end
               end
            end
            UPK_TASK: begin
               if (task_done_in) begin
                  task_ix_q <= first_task(task_en, task_ix_q + 3'h1);
                  task_req_out <=
                     5'(5'h01 << first_task(task_en, task_ix_q + 3'h1));
                  if (first_task(task_en, task_ix_q + 3'h1)
                      >= 3'(`PBU_NTASK)) begin
                     // store only once every calibration is done
                     if (ucfg[`PBU_UCFG_STORE]) begin
                        upk_state_q <= UPK_STORE; // see RULE8
                     end else if (host_irq_out) begin
                        upk_state_q <= UPK_HOLD;
                     end else begin
                        upk_state_q <= UPK_SLEEP;
                     end
                  end
               end
            end
            UPK_STORE: begin
               upk_state_q <= host_irq_out ? UPK_HOLD : UPK_SLEEP;
            end
            UPK_HOLD: begin
               if (idle_ret) begin
                  upk_state_q <= UPK_SLEEP; // see RULE13
                  host_irq_out <= 1'b0;
                  sysclk_en_out <= 1'b0;
               end
            end
         endcase
      end
   end

   always_comb begin
      rd_val = 8'h00;
      if (addr_ix(reg_addr_in) != `PBU_IX_NONE) begin
         rd_val = bank_q[addr_ix(reg_addr_in)];
      end else if (reg_addr_in == `PBU_STAT1_ADDR) begin
         rd_val[`PBU_STAT1_CSUM_OK] = csum_ok_q;
         rd_val[`PBU_STAT1_UPK_BUSY] = upk_state_q != UPK_OFF
                                       && upk_state_q != UPK_SLEEP;
      end else if (reg_addr_in == `PBU_STAT2_ADDR) begin
         rd_val[`PBU_STAT2_LOAD_ERR] = load_err_q;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         reg_rdata_out <= rd_val;
      end
   end

   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!rstn_in);

   sequence load_bad_s;
      load_go && !load_ok;
   endsequence
   sequence hold_end_s;
      upk_state_q == UPK_HOLD ##0 idle_ret;
   endsequence
   sequence wake_start_s;
      upk_state_q == UPK_SLEEP && upk_en && upk_exp ##0 ucfg[6];
   endsequence

   chk_timed_payload_gate: assert property ( // see RULE3
      (burst_tx_out && !burst_src_out) |->
      burst_payload_valid_out == ($past(bank_q[`PBU_IX_TPAY]) != 8'h00))
      else $error("timed payload flag does not match its byte");
   chk_trig_payload_gate: assert property ( // see RULE4
      (burst_tx_out && burst_src_out) |->
      burst_payload_valid_out == ($past(bank_q[`PBU_IX_XPAY]) != 8'h00))
      else $error("triggered payload flag does not match its byte");
   chk_upkeep_stays_off: assert property ( // see RULE5
      (upk_state_q == UPK_OFF && !upk_en) |=> upk_state_q == UPK_OFF)
      else $error("upkeep woke while disabled");
   chk_wake_raises_irq: assert property ( // see RULE7
      wake_start_s |=> host_irq_out && sysclk_en_out)
      else $error("upkeep wake did not raise interrupt and clock");
   chk_store_after_cals: assert property ( // see RULE8
      upk_state_q == UPK_STORE |-> task_req_out == 5'h00)
      else $error("store started while a task was pending");
   chk_idle_return_ends: assert property ( // see RULE13
      hold_end_s |=> upk_state_q == UPK_SLEEP && !host_irq_out)
      else $error("idle return did not end the upkeep cycle");
   chk_store_checksum: assert property ( // see RULE14
      nvm_store_out |-> csum(nvm_q) == nvm_sum_q
      && nvm_q[`PBU_IX_UCFG] == $past(bank_q[`PBU_IX_UCFG]))
      else $error("stored image and checksum disagree");
   chk_bad_load_kept: assert property ( // see RULE16
      load_bad_s |=> load_err_q
      && bank_q[`PBU_IX_UPER] == $past(bank_q[`PBU_IX_UPER]))
      else $error("failed reload changed bank or missed error bit");
   chk_one_task_at_time: assert property ( // see RULE18
      $onehot0(task_req_out) && (upk_state_q == UPK_TASK
      || task_req_out == 5'h00))
      else $error("more than one upkeep task requested");
endmodule

// >>> tb/pbu_task_partner.sv
// Purpose: far-side model that answers upkeep task requests
// Assumes: requests are one-hot levels held until the done pulse
// Notes: slow_in stretches every answer, as a busy converter would
`timescale 1ns/1ps

module pbu_task_partner (
   input wire logic mclk_in,
   input wire logic rstn_in,
   input wire logic [4:0] task_req_in,
   input wire logic slow_in,
   output logic task_done_out
);
   logic [3:0] wait_q;
   logic [3:0] lim;
   assign lim = slow_in ? 4'h9 : 4'h0;
   // one pulse per request; the gap cycle keeps a held request from
   // being answered twice
   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         wait_q <= 4'h0;
         task_done_out <= 1'b0;
      end else begin
         task_done_out <= 1'b0;
         if (task_done_out || task_req_in == 5'h00) begin
            wait_q <= 4'h0;
         end else if (wait_q == lim) begin
            task_done_out <= 1'b1;
         end else begin
            wait_q <= wait_q + 4'h1;
         end
      end
   end
endmodule

// >>> tb/pbu_top_test.sv
// Purpose: self-checking bench for pbu_top
// Assumes: base tick cut to 4 clocks so interval timers stay short
// Notes: a failed-checksum load cannot be provoked from the ports
`timescale 1ns/1ps
`include "pbu_regs.svh"

module pbu_top_test;
   localparam int TICK = 4;
   localparam logic [7:0] REGS [5] = '{`PBU_BPER_ADDR, `PBU_UCFG_ADDR,
      `PBU_UPER_ADDR, `PBU_TPAY_ADDR, `PBU_XPAY_ADDR};
   logic mclk_in = 1'b0;
   logic rstn_in;
   logic wr_s, rd_s, trig, done, slow, tx, src, pval, irq, sclk, store;
   logic [7:0] addr, wdata, rdata, pay, pay_l;
   logic [4:0] req, req_q;
   logic [4:0] seen [$];
   logic src_l, val_l, irq_at_req;
   int err_total = 0;
   int total_checks = 0;
   int cyc = 0;
   int bcnt = 0;
   int t_last = 0;
   int t_prev = 0;
   int scnt = 0;
   int bad_store = 0;
   int req_t = 0;

   always #5 mclk_in = ~mclk_in;

   pbu_top #(.BASE_TICK_CYC(TICK)) dut_u (.mclk_in(mclk_in),
      .rstn_in(rstn_in), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .burst_trig_in(trig),
      .task_done_in(done), .reg_rdata_out(rdata), .burst_tx_out(tx),
      .burst_src_out(src), .burst_payload_valid_out(pval),
      .burst_payload_out(pay), .task_req_out(req), .host_irq_out(irq),
      .sysclk_en_out(sclk), .nvm_store_out(store));

   pbu_task_partner host_u (.mclk_in(mclk_in), .rstn_in(rstn_in),
      .task_req_in(req), .slow_in(slow), .task_done_out(done));

   task automatic summarize();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // event log; timeout ceiling covers the long coarse upkeep sleep
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      if (tx === 1'b1) begin
         bcnt <= bcnt + 1;
         t_prev <= t_last;
         t_last <= cyc;
         src_l <= src;
         pay_l <= pay;
         val_l <= pval;
      end
      if (req !== 5'h00 && req !== req_q) begin
         if (seen.size() == 0) irq_at_req <= irq;
         seen.push_back(req);
         req_t <= cyc;
      end
      req_q <= req;
      if (store === 1'b1) scnt <= scnt + 1;
      if (store === 1'b1 && req !== 5'h00) bad_store <= bad_store + 1;
      if (cyc > 40000) begin
         err_total++;
         summarize();
      end
   end

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
         input string what);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_span(input int got, input int lo, input int hi,
         input string what);
      total_checks++;
      if (got < lo || got > hi) begin
         err_total++;
         $display("CHECK FAILED %0t %s got %0d", $time, what, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk_in);
      addr = a;
      wdata = d;
      wr_s = 1'b1;
      @(negedge mclk_in);
      wr_s = 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] mask,
         input logic [7:0] exp, input string what);
      @(negedge mclk_in);
      addr = a;
      rd_s = 1'b1;
      @(negedge mclk_in);
      rd_s = 1'b0;
      @(negedge mclk_in);
      chk8(rdata & mask, exp, what);
   endtask

   task automatic wait_burst(input int n);
      int goal;
      goal = bcnt + n;
      repeat (n * 1300) begin
         if (bcnt >= goal) break;
         @(negedge mclk_in);
      end
      chk_span(bcnt, goal, goal, "burst count");
   endtask

   task automatic wait_req(input int lim);
      repeat (lim) begin
         if (seen.size() > 0) break;
         @(negedge mclk_in);
      end
      chk_span(seen.size(), 1, 5, "upkeep start");
   endtask

   task automatic wait_store();
      int s0;
      s0 = scnt;
      repeat (300) begin
         if (scnt > s0) break;
         @(negedge mclk_in);
      end
      repeat (2) @(negedge mclk_in);
      chk_span(scnt, s0 + 1, s0 + 1, "store pulse");
   endtask

   task automatic pulse_trig(input int n);
      int goal;
      goal = bcnt + n;
      @(negedge mclk_in);
      trig = 1'b1;
      repeat (8) @(negedge mclk_in);
      trig = 1'b0;
      repeat (4) @(negedge mclk_in);
      chk_span(bcnt, goal, goal, "trigger burst count");
   endtask

   task automatic t_regs();
      for (int i = 0; i < 5; i++) begin
         rdchk(REGS[i], 8'hff, 8'h00, "reset value");
         wr(REGS[i], REGS[i] ^ 8'ha5);
         rdchk(REGS[i], 8'hff, REGS[i] ^ 8'ha5, "readback");
      end
      wr(8'h55, 8'h33);
      rdchk(8'h55, 8'hff, 8'h00, "unmapped read");
      rdchk(`PBU_CMD_ADDR, 8'hff, 8'h00, "command read");
   endtask

   task automatic t_bursts();
      wr(`PBU_BCFG_ADDR, 8'h00);
      wr(`PBU_BPER_ADDR, 8'h02);
      wr(`PBU_TPAY_ADDR, 8'ha5);
      wr(`PBU_IDLE_ADDR, 8'h02);
      wait_burst(3);
      chk_span(t_last - t_prev, 3 * TICK, 3 * TICK, "fine spacing");
      chk8({7'h00, src_l}, 8'h00, "timed source");
      chk8(pay_l, 8'ha5, "timed payload");
      chk8({7'h00, val_l}, 8'h01, "payload used");
      wr(`PBU_TPAY_ADDR, 8'h00);
      wait_burst(2);
      chk8({7'h00, val_l}, 8'h00, "zero payload dropped");
      // stop the timer first: a period cut below the running count
      // would expire early
      wr(`PBU_IDLE_ADDR, 8'h00);
      wr(`PBU_BCFG_ADDR, 8'h01);
      wr(`PBU_BPER_ADDR, 8'h00);
      wr(`PBU_IDLE_ADDR, 8'h02);
      wait_burst(3);
      chk_span(t_last - t_prev, 300 * TICK, 300 * TICK, "coarse gap");
      wr(`PBU_IDLE_ADDR, 8'h00);
      wr(`PBU_BPER_ADDR, 8'hff);
      wr(`PBU_XPAY_ADDR, 8'h5a);
      wr(`PBU_IDLE_ADDR, 8'h02);
      pulse_trig(1);
      chk8({src_l, pay_l[6:0]}, 8'hda, "triggered payload");
      chk8({7'h00, val_l}, 8'h01, "triggered used");
      wr(`PBU_XPAY_ADDR, 8'h00);
      pulse_trig(1);
      chk8({7'h00, val_l}, 8'h00, "zero trigger byte");
      wr(`PBU_IDLE_ADDR, 8'h00);
      pulse_trig(0);
   endtask

   task automatic t_nvm();
      wr(`PBU_TPAY_ADDR, 8'h3c);
      wr(`PBU_CMD_ADDR, `PBU_CMD_STORE);
      wait_store();
      wr(`PBU_TPAY_ADDR, 8'h99);
      wr(`PBU_CMD_ADDR, `PBU_CMD_LOAD);
      repeat (3) @(negedge mclk_in);
      rdchk(`PBU_TPAY_ADDR, 8'hff, 8'h3c, "reloaded byte");
      rdchk(`PBU_STAT1_ADDR, 8'h04, 8'h04, "checksum good");
      rdchk(`PBU_STAT2_ADDR, 8'h01, 8'h00, "no load error");
   endtask

   task automatic t_upkeep();
      int t0;
      slow = 1'b0;
      seen.delete();
      wr(`PBU_UPER_ADDR, 8'h01);
      wr(`PBU_UCFG_ADDR, 8'h7f);
      wr(`PBU_IDLE_ADDR, 8'h01);
      t0 = cyc;
      wait_req(300);
      chk_span(req_t - t0, 152, 168, "first sleep");
      wait_store();
      chk_span(bad_store, 0, 0, "store during task");
      chk_span(seen.size(), 5, 5, "task count");
      for (int i = 0; i < 5; i++) begin
         chk8({3'h0, seen[i]}, 8'h01 << i, "task order");
      end
      chk8({7'h00, irq_at_req}, 8'h01, "wake at start");
      chk8({6'h00, irq, sclk}, 8'h03, "wake held");
      rdchk(`PBU_STAT1_ADDR, 8'h01, 8'h01, "cycle active");
      wr(`PBU_CMD_ADDR, `PBU_CMD_IDLE);
      t0 = cyc;
      @(negedge mclk_in);
      chk8({6'h00, irq, sclk}, 8'h00, "idle return");
      slow = 1'b1;
      seen.delete();
      wait_req(300);
      chk_span(req_t - t0, 152, 168, "timer restart");
      wait_store();
      wr(`PBU_IDLE_ADDR, 8'h00);
      wr(`PBU_CMD_ADDR, `PBU_CMD_IDLE);
      seen.delete();
      repeat (400) @(negedge mclk_in);
      chk_span(seen.size(), 0, 0, "upkeep disabled");
      wr(`PBU_UPER_ADDR, 8'h00);
      wr(`PBU_UCFG_ADDR, 8'h81);
      wr(`PBU_IDLE_ADDR, 8'h01);
      t0 = cyc;
      wait_req(24100);
      chk_span(req_t - t0, 6000 * TICK - 8, 6000 * TICK + 8, "coarse");
      chk8({3'h0, seen[0]}, 8'h10, "quick-start only");
      chk8({7'h00, irq_at_req}, 8'h00, "no wake");
      wr(`PBU_IDLE_ADDR, 8'h00);
   endtask

   initial begin
      rstn_in = 1'b0;
      wr_s = 1'b0;
      rd_s = 1'b0;
      trig = 1'b0;
      slow = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      repeat (4) @(posedge mclk_in);
      @(negedge mclk_in);
      rstn_in = 1'b1;
      t_regs();
      t_bursts();
      t_nvm();
      t_upkeep();
      summarize();
   end
endmodule
